// ==== shared/pls_pkg.sv ====
package pls_pkg;
  localparam int unsigned NCH = 8;
  // Register page addresses
  localparam logic [15:0] ADDR_PIN_STATE = 16'h0088;
  localparam logic [15:0] ADDR_OUT_LATCH = 16'h0089;
  localparam logic [15:0] ADDR_ACT_LATCH = 16'h008A;
  localparam logic [15:0] ADDR_SRCH_MASK = 16'h008B;
  localparam logic [15:0] ADDR_SRCH_POL = 16'h008C;
  localparam logic [15:0] ADDR_CTRL_STAT = 16'h008D;
  localparam logic [15:0] ADDR_PAGE_END = 16'h008F;
  // Control/status field positions
  localparam int unsigned CS_SRC_BIT = 0;
  localparam int unsigned CS_COMB_BIT = 1;
  localparam int unsigned CS_PINMODE_BIT = 2;
  localparam int unsigned CS_PWRUP_BIT = 3;
  localparam int unsigned CS_SUPPLY_BIT = 7;
  // Writable control bits b3..b0
  localparam logic [7:0] CS_WR_MASK = 8'h0F;
  // Reset values and fixed fill/undefined byte constants
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [7:0] ACT_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h08;
  localparam logic [7:0] OUT_ALL_OFF = 8'hFF;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [7:0] UNDEF_BYTE = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Device command kinds seen by the register page
  typedef enum logic [2:0] {
    PLS_CMD_NONE,
    PLS_CMD_READ_REG,
    PLS_CMD_CHAN_WRITE,
    PLS_CMD_SRCH_WRITE,
    PLS_CMD_CLR_ACT
  } pls_cmd_t;
endpackage

// ==== shared/pls_srch_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// Search-condition inputs from the register page to the evaluator
interface pls_srch_if;
  logic [7:0] mask;
  logic [7:0] pol;
  logic [7:0] pins;
  logic [7:0] act;
  logic src_sel;
  logic comb_and;
  logic pwr_flag;
  logic match;
  modport page (output mask, output pol, output pins, output act, output src_sel, output comb_and,
                output pwr_flag, input match);
  modport eval (input mask, input pol, input pins, input act, input src_sel, input comb_and,
                input pwr_flag, output match);
endinterface
`default_nettype wire

// ==== logic/pls_srch_eval.sv ====
`timescale 1ns/100ps
`default_nettype none
module pls_srch_eval (
  pls_srch_if.eval s
);
  import pls_pkg::*;
  logic [7:0] src;
  logic [7:0] hit;
  logic any_hit;
  logic all_hit;
  // Pick source, compare to polarity, form both terms
  always_comb begin
    src = s.src_sel ? s.act : s.pins;
    hit = ~(src ^ s.pol) & s.mask;
    any_hit = |hit;
    all_hit = (s.mask != BYTE_ZERO) && (hit == s.mask);
    s.match = s.pwr_flag | (s.comb_and ? all_hit : any_hit);
  end
endmodule
`default_nettype wire

// ==== logic/pls_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module pls_regs (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic soft_reinit_i,
  input wire logic addressed_i,
  input wire logic high_speed_req_i,
  input wire logic high_speed_clr_i,
  input wire logic cmd_valid_i,
  input wire pls_pkg::pls_cmd_t cmd_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] channel_io_i,
  input wire logic reset_or_strobe_pin_i,
  input wire logic supply_present_i,
  input wire logic strobe_req_i,
  output logic [7:0] rdata_o,
  output logic rdata_valid_o,
  output logic [7:0] channel_io_oe_o,
  output logic [7:0] channel_io_o,
  output logic reset_or_strobe_pin_o,
  output logic reset_or_strobe_pin_oe_o,
  output logic search_response_o,
  output logic high_speed_flag_o
);
  import pls_pkg::*;

  logic [7:0] out_latch_r;
  logic [7:0] act_latch_r;
  logic [7:0] mask_r;
  logic [7:0] pol_r;
  logic [3:0] ctrl_r;
  logic supply_r;
  logic [7:0] pin_prev_r;
  logic pin_prev_vld_r;
  logic rst_pin_prev_r;
  logic [15:0] wr_addr_r;
  logic wr_open_r;
  logic strobe_r;
  logic [7:0] ctrl_view;
  logic cmd_ok;
  logic rst_pulse;
  logic rst_mode_in;
  logic [7:0] rd_byte;
  logic [15:0] srch_addr;

  pls_srch_if srch ();

  // Address-decoded read data of the register page
  function automatic logic [7:0] page_read(input logic [15:0] a, input logic [7:0] pins, input logic [7:0] ol,
                                            input logic [7:0] al, input logic [7:0] m, input logic [7:0] p,
                                            input logic [7:0] c);
    logic [7:0] v;
    v = UNDEF_BYTE;
    if (a == ADDR_PIN_STATE) begin
      v = pins;
    end else if (a == ADDR_OUT_LATCH) begin
      v = ol;
    end else if (a == ADDR_ACT_LATCH) begin
      v = al;
    end else if (a == ADDR_SRCH_MASK) begin
      v = m;
    end else if (a == ADDR_SRCH_POL) begin
      v = p;
    end else if (a == ADDR_CTRL_STAT) begin
      v = c;
    end else if (a > ADDR_CTRL_STAT && a <= ADDR_PAGE_END) begin
      v = FILL_BYTE;
    end
    return v;
  endfunction

  // Qualified command and reset-pin decode
  always_comb begin
    cmd_ok = cmd_valid_i && addressed_i;
    rst_mode_in = ~ctrl_r[CS_PINMODE_BIT];
    rst_pulse = rst_mode_in && rst_pin_prev_r && !reset_or_strobe_pin_i;
    ctrl_view = BYTE_ZERO;
    ctrl_view[CS_SUPPLY_BIT] = supply_r;
    ctrl_view[3:0] = ctrl_r;
    srch_addr = (cmd_i == PLS_CMD_SRCH_WRITE && !wr_open_r) ? addr_i : wr_addr_r;
    rd_byte = page_read(addr_i, channel_io_i, out_latch_r, act_latch_r, mask_r, pol_r, ctrl_view);
  end

  // Output latch: channel write or a reset-pin pulse changes it; soft reinit leaves it alone
  always_ff @(posedge sys_clk_i) begin
    if (rst_pulse) begin
      out_latch_r <= OUT_ALL_OFF;
    end else if (cmd_ok && cmd_i == PLS_CMD_CHAN_WRITE) begin
      out_latch_r <= wdata_i;
    end
  end

  // Pin history for transition detection
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      pin_prev_r <= BYTE_ZERO;
      pin_prev_vld_r <= 1'b0;
      rst_pin_prev_r <= 1'b1;
    end else begin
      pin_prev_r <= channel_io_i;
      pin_prev_vld_r <= 1'b1;
      rst_pin_prev_r <= reset_or_strobe_pin_i;
    end
  end

  // Activity latches: set on any edge, set wins over clear
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      act_latch_r <= ACT_RST;
    end else if (rst_pulse || (cmd_ok && cmd_i == PLS_CMD_CLR_ACT)) begin
      act_latch_r <= pin_prev_vld_r ? (channel_io_i ^ pin_prev_r) : ACT_RST;
    end else if (pin_prev_vld_r) begin
      act_latch_r <= act_latch_r | (channel_io_i ^ pin_prev_r);
    end
  end

  // Search-register write pointer, auto-increments on every search write, also past control register
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || !addressed_i) begin
      wr_open_r <= 1'b0;
      wr_addr_r <= ADDR_SRCH_MASK;
    end else if (cmd_ok && cmd_i == PLS_CMD_SRCH_WRITE) begin
      wr_open_r <= 1'b1;
      wr_addr_r <= 16'(srch_addr + 16'h0001);
    end
  end

  // Mask, polarity and control registers
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      mask_r <= MASK_RST;
      pol_r <= POL_RST;
      ctrl_r <= CTRL_RST[3:0];
    end else if (cmd_ok && cmd_i == PLS_CMD_SRCH_WRITE) begin
      if (srch_addr == ADDR_SRCH_MASK) begin
        mask_r <= wdata_i;
      end else if (srch_addr == ADDR_SRCH_POL) begin
        pol_r <= wdata_i;
      end else if (srch_addr == ADDR_CTRL_STAT) begin
        ctrl_r <= wdata_i[3:0] & CS_WR_MASK[3:0];
      end
    end
  end

  // Supply status sampled each cycle
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      supply_r <= 1'b0;
    end else begin
      supply_r <= supply_present_i;
    end
  end

  // Speed flag: standard unless explicitly raised
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || high_speed_clr_i) begin
      high_speed_flag_o <= 1'b0;
    end else if (high_speed_req_i) begin
      high_speed_flag_o <= 1'b1;
    end
  end

  // Register read port; reads never touch the strobe
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rdata_o <= BYTE_ZERO;
      rdata_valid_o <= 1'b0;
    end else begin
      rdata_valid_o <= cmd_ok && cmd_i == PLS_CMD_READ_REG;
      rdata_o <= rd_byte;
    end
  end

  // Strobe only from channel-access requests, never from register reads
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      strobe_r <= 1'b0;
    end else begin
      strobe_r <= strobe_req_i && ctrl_r[CS_PINMODE_BIT] && !(cmd_valid_i && cmd_i == PLS_CMD_READ_REG);
    end
  end

  // Pin drivers: open drain, drive low only
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      channel_io_oe_o <= BYTE_ZERO;
      channel_io_o <= BYTE_ZERO;
      reset_or_strobe_pin_oe_o <= 1'b0;
      reset_or_strobe_pin_o <= 1'b0;
    end else begin
      channel_io_oe_o <= rst_pulse ? BYTE_ZERO : ~out_latch_r;
      channel_io_o <= BYTE_ZERO;
      reset_or_strobe_pin_oe_o <= strobe_r;
      reset_or_strobe_pin_o <= 1'b0;
    end
  end

  assign srch.mask = mask_r;
  assign srch.pol = pol_r;
  assign srch.pins = channel_io_i;
  assign srch.act = act_latch_r;
  assign srch.src_sel = ctrl_r[CS_SRC_BIT];
  assign srch.comb_and = ctrl_r[CS_COMB_BIT];
  assign srch.pwr_flag = ctrl_r[CS_PWRUP_BIT];

  pls_srch_eval u_eval (
    .s(srch)
  );

  // Registered search response
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      search_response_o <= 1'b1;
    end else begin
      search_response_o <= srch.match;
    end
  end
endmodule
`default_nettype wire

// ==== verif/pls_regs_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module pls_regs_assertions (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic addressed_i,
  input wire logic high_speed_req_i,
  input wire logic high_speed_clr_i,
  input wire logic cmd_valid_i,
  input wire pls_pkg::pls_cmd_t cmd_i,
  input wire logic [7:0] wdata_i,
  input wire logic strobe_req_i,
  input wire logic rdata_valid_o,
  input wire logic [7:0] channel_io_oe_o,
  input wire logic reset_or_strobe_pin_oe_o,
  input wire logic search_response_o,
  input wire logic high_speed_flag_o
);
  import pls_pkg::*;
  // One clock domain, checks paused in reset except a_reset_values
  default clocking dc @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_read_answer: assert property (cmd_valid_i && addressed_i && cmd_i == PLS_CMD_READ_REG
    |=> rdata_valid_o) else $error("read not answered");
  a_read_refused: assert property (cmd_valid_i && !addressed_i |=> !rdata_valid_o)
    else $error("read answered while not addressed");
  a_valid_cause: assert property (rdata_valid_o
    |-> $past(cmd_valid_i && addressed_i && cmd_i == PLS_CMD_READ_REG)) else $error("stray read data");
  a_no_stray_strobe: assert property (!strobe_req_i [*4] |=> !$rose(reset_or_strobe_pin_oe_o))
    else $error("strobe without request");
  a_chan_write: assert property (cmd_valid_i && addressed_i && cmd_i == PLS_CMD_CHAN_WRITE
    |=> ##1 channel_io_oe_o == ~$past(wdata_i, 2)) else $error("outputs not the written byte");
  a_speed_set: assert property (high_speed_req_i && !high_speed_clr_i |=> high_speed_flag_o)
    else $error("speed flag not set");
  a_speed_clear: assert property (high_speed_clr_i |=> !high_speed_flag_o)
    else $error("speed flag not cleared");
  a_speed_hold: assert property (!high_speed_req_i |=> !$rose(high_speed_flag_o))
    else $error("speed flag rose unasked");
  a_reset_values: assert property (disable iff (1'h0) !reset_n_i
    |=> search_response_o && !high_speed_flag_o && !rdata_valid_o) else $error("bad reset outputs");
endmodule
bind pls_regs pls_regs_assertions u_pls_regs_assertions (.sys_clk_i, .reset_n_i, .addressed_i,
  .high_speed_req_i, .high_speed_clr_i, .cmd_valid_i, .cmd_i, .wdata_i, .strobe_req_i, .rdata_valid_o,
  .channel_io_oe_o, .reset_or_strobe_pin_oe_o, .search_response_o, .high_speed_flag_o);
`default_nettype wire

// ==== verif/pls_master_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module pls_master_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rdata_valid_i,
  output logic addressed_o,
  output logic cmd_valid_o,
  output pls_pkg::pls_cmd_t cmd_o,
  output logic [15:0] addr_o,
  output logic [7:0] wdata_o
);
  import pls_pkg::*;
  // Bus idle, addressing already done
  initial begin
    addressed_o = 1'h1;
    cmd_valid_o = 1'h0;
    cmd_o = PLS_CMD_NONE;
    addr_o = 16'h0000;
    wdata_o = 8'h00;
  end
  // One command cycle; released fields show inverted data
  task automatic go(input pls_cmd_t c, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cmd_valid_o <= 1'h1;
    cmd_o <= c;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    cmd_valid_o <= 1'h0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // Read answer is registered on the taking edge itself; sampled 1 ns after it
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    go(PLS_CMD_READ_REG, a, 8'h00);
    #1;
    d = (rdata_valid_i === 1'h1) ? rdata_i : 8'hxx;
  endtask
  // Fresh write reopens the session so the start address counts
  task automatic sw(input bit fresh, input logic [15:0] a, input logic [7:0] d);
    if (fresh) begin
      @(posedge clk_i);
      addressed_o <= 1'h0;
      @(posedge clk_i);
      addressed_o <= 1'h1;
    end
    go(PLS_CMD_SRCH_WRITE, a, d);
  endtask
endmodule
`default_nettype wire

// ==== verif/pls_regs_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module pls_regs_bench;
  import pls_pkg::*;
  logic sys_clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic reinit = 1'h0;
  logic hs_req = 1'h0;
  logic hs_clr = 1'h0;
  logic supply = 1'h0;
  logic stb_req = 1'h0;
  logic ext_rst = 1'h1;
  logic [7:0] ext_pins = 8'h00;
  logic addressed, cmd_valid, rs_oe, rvalid, resp, hs_flag;
  pls_cmd_t cmd;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, oe, v, src, m;
  logic [23:0] tbl [6] = '{24'h03_0100, 24'h03_0200, 24'h03_0002, 24'h03_0103, 24'h01_0002, 24'h03_0201};
  int compares = 0;
  int miscompares = 0;
  // Open-drain wires: any driver low wins
  wire logic [7:0] pins_w = ext_pins & ~oe;
  wire logic rst_w = ext_rst & ~rs_oe;
  always #12.5 sys_clk_i = ~sys_clk_i;
  pls_regs u_pls_regs (.sys_clk_i, .reset_n_i, .soft_reinit_i(reinit), .addressed_i(addressed),
    .high_speed_req_i(hs_req), .high_speed_clr_i(hs_clr), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
    .addr_i(addr), .wdata_i(wdata), .channel_io_i(pins_w), .reset_or_strobe_pin_i(rst_w),
    .supply_present_i(supply), .strobe_req_i(stb_req), .rdata_o(rdata), .rdata_valid_o(rvalid),
    .channel_io_oe_o(oe), .channel_io_o(), .reset_or_strobe_pin_o(), .reset_or_strobe_pin_oe_o(rs_oe),
    .search_response_o(resp), .high_speed_flag_o(hs_flag));
  pls_master_model u_pls_master_model (.clk_i(sys_clk_i), .rdata_i(rdata), .rdata_valid_i(rvalid),
    .addressed_o(addressed), .cmd_valid_o(cmd_valid), .cmd_o(cmd), .addr_o(addr), .wdata_o(wdata));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_expect(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_pls_master_model.rd(a, d);
    check(d, exp);
  endtask
  task automatic report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog far beyond the expected run
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    miscompares++;
    report_and_stop;
  end
  // Pins held low by the outside world while the latch is unknown
  initial begin
    repeat (6) @(posedge sys_clk_i);
    reset_n_i <= 1'h1;
    rd_expect(ADDR_ACT_LATCH, 8'h00);
    rd_expect(ADDR_SRCH_MASK, 8'h00);
    rd_expect(ADDR_SRCH_POL, 8'h00);
    rd_expect(ADDR_CTRL_STAT, 8'h08);
    check({7'h00, resp}, 8'h01);
    check({7'h00, hs_flag}, 8'h00);
    $display("test reset done");
    @(posedge sys_clk_i) ext_rst <= 1'h0;
    repeat (2) @(posedge sys_clk_i);
    ext_rst <= 1'h1;
    repeat (3) @(posedge sys_clk_i);
    ext_pins <= 8'hff;
    #1 check(oe, 8'h00);
    rd_expect(ADDR_OUT_LATCH, 8'hff);
    u_pls_master_model.go(PLS_CMD_CLR_ACT, 16'h0000, 8'h00);
    rd_expect(ADDR_ACT_LATCH, 8'h00);
    u_pls_master_model.go(PLS_CMD_CHAN_WRITE, 16'h0000, 8'h5a);
    repeat (3) @(posedge sys_clk_i);
    #1 check(oe, 8'ha5);
    rd_expect(ADDR_ACT_LATCH, 8'ha5);
    @(posedge sys_clk_i) reinit <= 1'h1;
    @(posedge sys_clk_i) reinit <= 1'h0;
    rd_expect(ADDR_OUT_LATCH, 8'h5a);
    $display("test latches done");
    u_pls_master_model.sw(1'h1, ADDR_CTRL_STAT, 8'hf0);
    rd_expect(ADDR_CTRL_STAT, 8'h00);
    @(posedge sys_clk_i) supply <= 1'h1;
    rd_expect(ADDR_CTRL_STAT, 8'h80);
    u_pls_master_model.sw(1'h1, ADDR_OUT_LATCH, 8'h00);
    rd_expect(ADDR_OUT_LATCH, 8'h5a);
    // Mask, polarity and control by one auto-incrementing sequence
    for (int i = 0; i < 6; i++) begin
      u_pls_master_model.sw(1'h1, ADDR_SRCH_MASK, tbl[i][23:16]);
      u_pls_master_model.sw(1'h0, 16'h0000, tbl[i][15:8]);
      u_pls_master_model.sw(1'h0, 16'h0000, tbl[i][7:0]);
      rd_expect(ADDR_SRCH_POL, tbl[i][15:8]);
      src = tbl[i][0] ? 8'ha5 : 8'h5a;
      m = ~(src ^ tbl[i][15:8]) & tbl[i][23:16];
      v = {7'h00, tbl[i][1] ? (m == tbl[i][23:16]) : (|m)};
      check({7'h00, resp}, v);
    end
    $display("test search done");
    u_pls_master_model.sw(1'h1, ADDR_CTRL_STAT, 8'h04);
    @(posedge sys_clk_i) stb_req <= 1'h1;
    @(posedge sys_clk_i) stb_req <= 1'h0;
    @(posedge sys_clk_i);
    #1 check({7'h00, rs_oe}, 8'h01);
    rd_expect(ADDR_ACT_LATCH, 8'ha5);
    #1 check({7'h00, rs_oe}, 8'h00);
    @(posedge sys_clk_i) hs_req <= 1'h1;
    @(posedge sys_clk_i) hs_req <= 1'h0;
    #1 check({7'h00, hs_flag}, 8'h01);
    @(posedge sys_clk_i) hs_clr <= 1'h1;
    @(posedge sys_clk_i) hs_clr <= 1'h0;
    #1 check({7'h00, hs_flag}, 8'h00);
    $display("test strobe and speed done");
    report_and_stop;
  end
endmodule
`default_nettype wire
